// ==== design/gph_ctrl.sv ====
// bus controller: drives atn/ifc/ren, sources command and data bytes, accepts talker bytes
// How it works
// - bytes move one per handshake on eight data lines, data and commands alike
// - every line is low true; driven low means true, released means false
// - the controller addresses at most one talker; any number of listeners
// - at most 15 devices on one bus, controller included
// - bytes under atn are commands; bytes without atn are device data
// - source asserts eoi with the last byte; acceptors use it as end
// - only the source drives dav; acceptors drive nrfd and ndac, wired-or low
// - source raises dav only after nrfd high and ndac low
// - after atn goes true, controller waits 100ns before the handshake
// - on dav low acceptor pulls nrfd low, releases ndac after latching
// - controller times out a stalled handshake and reports an error
// - on ndac high source drops dav; acceptor then reasserts ndac
module gph_ctrl #(
    parameter int unsigned TIMEOUT_CYC = gph_pkg::TIMEOUT_CYC_DEF,
    parameter int unsigned IFC_CYC     = gph_pkg::IFC_CYC_DEF
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  rst_n_i,
    input  wire logic                  cmd_valid_i,
    input  wire gph_pkg::gph_cmd_t     cmd_i,
    output logic                       cmd_ready_o,
    output logic                       rsp_valid_o,
    output gph_pkg::gph_rsp_t          rsp_o,
    input  wire gph_pkg::gph_pin_in_t  pins_i,
    output gph_pkg::gph_pin_out_t      pins_o,
    output logic                       srq_o
);

    localparam gph_pkg::gph_cnt_t TMO_LAST    = gph_pkg::gph_cnt_t'(TIMEOUT_CYC - 1);
    localparam gph_pkg::gph_cnt_t IFC_LAST    = gph_pkg::gph_cnt_t'(IFC_CYC - 1);
    localparam gph_pkg::gph_cnt_t SETTLE_LAST = gph_pkg::gph_cnt_t'(gph_pkg::ATN_SETTLE_CYC - 1);
    localparam int                SETTLE_MIN  = gph_pkg::ATN_SETTLE_CYC;

    // ==========================================================
    // state
    gph_pkg::gph_pin_in_t  s1_q;
    gph_pkg::gph_pin_in_t  s2_q;
    gph_pkg::gph_state_t   state_q;
    gph_pkg::gph_state_t   state_d;
    gph_pkg::gph_cnt_t     cnt_q;
    gph_pkg::gph_cnt_t     cnt_d;
    gph_pkg::gph_cmd_t     cur_q;
    gph_pkg::gph_cmd_t     cur_d;
    gph_pkg::gph_rsp_t     rsp_q;
    gph_pkg::gph_rsp_t     rsp_d;
    gph_pkg::gph_pin_out_t pins_q;
    gph_pkg::gph_pin_out_t pins_d;
    logic                  atn_q;
    logic                  atn_d;
    logic                  ren_q;
    logic                  ren_d;
    logic                  srq_q;
    logic                  ready_q;
    logic                  rsp_valid_q;

    // ==========================================================
    // decode
    wire src_ok    = s2_q.nrfd & ~s2_q.ndac;
    wire dav_true  = ~s2_q.dav;
    wire tmo       = (cnt_q >= TMO_LAST);
    wire settled   = (cnt_q >= SETTLE_LAST);
    wire src_st    = (state_d == gph_pkg::ST_SETTLE) || (state_d == gph_pkg::ST_SRC_WAIT)
                     || (state_d == gph_pkg::ST_SRC_DAV);
    wire is_src    = src_st && (cur_d.op != gph_pkg::OP_RECV);
    wire listening = (cur_d.op == gph_pkg::OP_RECV);

    // ==========================================================
    // next state
    always_comb begin
        state_d = state_q;
        cur_d   = cur_q;
        rsp_d   = rsp_q;
        atn_d   = atn_q;
        ren_d   = ren_q;
        case (state_q)
            gph_pkg::ST_IDLE: begin
                // ready_q stays low for a cycle after reset, so nothing is taken then
                if (cmd_valid_i && ready_q) begin
                    cur_d = cmd_i;
                    rsp_d = '0;
                    case (cmd_i.op)
                        gph_pkg::OP_CMD: begin
                            atn_d   = 1'b1;
                            state_d = gph_pkg::ST_SETTLE;
                        end
                        gph_pkg::OP_DATA, gph_pkg::OP_RECV: begin
                            atn_d   = 1'b0;
                            state_d = gph_pkg::ST_SETTLE;
                        end
                        default: begin
                            ren_d   = cmd_i.data[gph_pkg::REN_BIT];
                            state_d = cmd_i.data[gph_pkg::IFC_BIT] ? gph_pkg::ST_IFC : gph_pkg::ST_FIN;
                        end
                    endcase
                end
            end
            gph_pkg::ST_SETTLE: begin
                // lines must sit still a while after atn moves
                if (settled) begin
                    state_d = listening ? gph_pkg::ST_ACC_RDY : gph_pkg::ST_SRC_WAIT;
                end
            end
            gph_pkg::ST_SRC_WAIT: begin
                if (src_ok) begin
                    state_d = gph_pkg::ST_SRC_DAV;
                end else if (tmo) begin
                    rsp_d.err = 1'b1;
                    state_d   = gph_pkg::ST_FIN;
                end
            end
            gph_pkg::ST_SRC_DAV: begin
                if (s2_q.ndac) begin
                    state_d = gph_pkg::ST_FIN;
                end else if (tmo) begin
                    rsp_d.err = 1'b1;
                    state_d   = gph_pkg::ST_FIN;
                end
            end
            gph_pkg::ST_ACC_RDY: begin
                if (dav_true) begin
                    rsp_d.data = ~s2_q.dio;
                    rsp_d.eoi  = ~s2_q.eoi;
                    state_d    = gph_pkg::ST_ACC_HOLD;
                end else if (tmo) begin
                    rsp_d.err = 1'b1;
                    state_d   = gph_pkg::ST_FIN;
                end
            end
            gph_pkg::ST_ACC_HOLD: begin
                if (!dav_true) begin
                    state_d = gph_pkg::ST_FIN;
                end else if (tmo) begin
                    rsp_d.err = 1'b1;
                    state_d   = gph_pkg::ST_FIN;
                end
            end
            gph_pkg::ST_IFC: begin
                if (cnt_q >= IFC_LAST) begin
                    state_d = gph_pkg::ST_FIN;
                end
            end
            gph_pkg::ST_FIN: begin
                state_d = gph_pkg::ST_IDLE;
            end
            default: begin
                state_d = gph_pkg::ST_IDLE;
            end
        endcase
    end

    assign cnt_d = (state_d != state_q) ? '0 : cnt_q + 1'b1;

    // ==========================================================
    // line drive; all open drain, so a true line is oe high with value low
    // open drain only, so any of up to 15 loads can share a line
    // listener holds nrfd and ndac low outside its two handshake states, which stalls the talker
    always_comb begin
        pins_d         = '0;
        pins_d.dio_oe  = is_src ? cur_d.data : 8'h00;
        pins_d.dav_oe  = (state_d == gph_pkg::ST_SRC_DAV);
        pins_d.eoi_oe  = is_src && (cur_d.op == gph_pkg::OP_DATA) && cur_d.eoi;
        pins_d.nrfd_oe = listening && (state_d != gph_pkg::ST_ACC_RDY);
        pins_d.ndac_oe = listening && (state_d != gph_pkg::ST_ACC_HOLD);
        pins_d.atn_oe  = atn_d;
        pins_d.ifc_oe  = (state_d == gph_pkg::ST_IFC);
        pins_d.ren_oe  = ren_d;
    end

    // ==========================================================
    // registers
    // lines read as released in reset, so no false srq shows after it
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= pins_i;
            s2_q <= s1_q;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q     <= gph_pkg::ST_IDLE;
            cnt_q       <= '0;
            cur_q       <= '0;
            rsp_q       <= '0;
            pins_q      <= '0;
            atn_q       <= 1'b0;
            ren_q       <= 1'b0;
            srq_q       <= 1'b0;
            ready_q     <= 1'b0;
            rsp_valid_q <= 1'b0;
        end else begin
            state_q     <= state_d;
            cnt_q       <= cnt_d;
            cur_q       <= cur_d;
            rsp_q       <= rsp_d;
            pins_q      <= pins_d;
            atn_q       <= atn_d;
            ren_q       <= ren_d;
            srq_q       <= ~s2_q.srq;
            ready_q     <= (state_d == gph_pkg::ST_IDLE);
            rsp_valid_q <= (state_d == gph_pkg::ST_FIN);
        end
    end

    assign cmd_ready_o = ready_q;
    assign rsp_valid_o = rsp_valid_q;
    assign rsp_o       = rsp_q;
    assign pins_o      = pins_q;
    assign srq_o       = srq_q;

    // ==========================================================
    // checks
    logic [7:0] atn_age_q;
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || (pins_d.atn_oe != pins_q.atn_oe)) begin
            atn_age_q <= 8'h00;
        end else if (atn_age_q != 8'hff) begin
            atn_age_q <= atn_age_q + 8'h01;
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence seen_dav_s;
        (state_q == gph_pkg::ST_ACC_RDY) && !s2_q.dav;
    endsequence
    sequence acc_latched_s;
        pins_q.nrfd_oe && !pins_q.ndac_oe && (rsp_q.data == ~$past(s2_q.dio));
    endsequence

    dav_gate_a: assert property ($rose(pins_q.dav_oe) |-> $past(src_ok))
        else $error("dav asserted before nrfd high and ndac low");
    atn_settle_a: assert property ($rose(pins_q.dav_oe) |-> atn_age_q >= SETTLE_MIN)
        else $error("handshake began too soon after atn change");
    dav_hold_a: assert property ((state_q == gph_pkg::ST_SRC_DAV) && !s2_q.ndac && !tmo
        |=> pins_q.dav_oe)
        else $error("dav dropped before data accepted");
    // rsp_valid is staged on the same edge that drops dav
    dav_drop_a: assert property ((state_q == gph_pkg::ST_SRC_DAV) && s2_q.ndac
        |=> !pins_q.dav_oe && (pins_q.dio_oe == 8'h00) && rsp_valid_o)
        else $error("source did not withdraw byte after ndac high");
    one_src_a: assert property (pins_q.dav_oe |-> !pins_q.nrfd_oe && !pins_q.ndac_oe)
        else $error("source drove acceptor lines");
    eoi_last_a: assert property (pins_q.eoi_oe
        |-> !pins_q.atn_oe && cur_q.eoi && pins_q.dio_oe == cur_q.data)
        else $error("eoi without a flagged data byte");
    cmd_atn_a: assert property ((state_q == gph_pkg::ST_SRC_WAIT)
        |-> pins_q.atn_oe == (cur_q.op == gph_pkg::OP_CMD))
        else $error("atn does not match byte kind");
    dio_level_a: assert property ((state_q == gph_pkg::ST_SRC_DAV) |-> pins_q.dio_oe == cur_q.data)
        else $error("data lines not low true");
    acc_take_a: assert property (seen_dav_s |=> acc_latched_s)
        else $error("acceptor did not latch and release ndac");
    acc_rearm_a: assert property ((state_q == gph_pkg::ST_ACC_HOLD) && s2_q.dav
        |=> pins_q.ndac_oe && pins_q.nrfd_oe ##1 pins_q.ndac_oe)
        else $error("ndac not reasserted after dav release");
    tmo_bound_a: assert property ((state_q == gph_pkg::ST_SRC_WAIT) && tmo && !src_ok
        |=> (state_q == gph_pkg::ST_FIN) && rsp_q.err)
        else $error("stalled handshake not timed out");

endmodule

// ==== design/gph_pkg.sv ====
// package: constants, line structs and command types for the bus controller
package gph_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS  = 5;
    localparam int ATN_SETTLE_NS  = 100;
    localparam int ATN_SETTLE_CYC = (ATN_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_TIMEOUT_US  = 1000;
    localparam int IFC_PULSE_US   = 100;
    localparam int TIMEOUT_CYC_DEF = (HS_TIMEOUT_US * 1000) / CLK_PERIOD_NS;
    localparam int IFC_CYC_DEF     = (IFC_PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W           = 24;

    typedef logic [CNT_W-1:0] gph_cnt_t;

    // ==========================================================
    // addressing
    localparam logic [7:0] LISTEN_OR = 8'h20;
    localparam logic [7:0] TALK_OR   = 8'h40;
    localparam logic [7:0] UNLISTEN  = 8'h3f;
    localparam logic [7:0] UNTALK    = 8'h5f;
    localparam int         REN_BIT   = 0;
    localparam int         IFC_BIT   = 1;

    function automatic logic [7:0] gph_listen_byte(input logic [4:0] pa);
        return LISTEN_OR | {3'h0, pa};
    endfunction

    function automatic logic [7:0] gph_talk_byte(input logic [4:0] pa);
        return TALK_OR | {3'h0, pa};
    endfunction

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        OP_CMD  = 2'h0,
        OP_DATA = 2'h1,
        OP_RECV = 2'h2,
        OP_LINE = 2'h3
    } gph_op_t;

    typedef enum logic [3:0] {
        ST_IDLE     = 4'h0,
        ST_SETTLE   = 4'h1,
        ST_SRC_WAIT = 4'h2,
        ST_SRC_DAV  = 4'h3,
        ST_ACC_RDY  = 4'h4,
        ST_ACC_HOLD = 4'h5,
        ST_IFC      = 4'h6,
        ST_FIN      = 4'h7
    } gph_state_t;

    typedef struct packed {
        gph_op_t    op;
        logic [7:0] data;
        logic       eoi;
    } gph_cmd_t;

    typedef struct packed {
        logic [7:0] data;
        logic       eoi;
        logic       err;
    } gph_rsp_t;

    // line levels as read: 0 means driven low, i.e. true
    typedef struct packed {
        logic [7:0] dio;
        logic       dav;
        logic       nrfd;
        logic       ndac;
        logic       eoi;
        logic       srq;
    } gph_pin_in_t;

    typedef struct packed {
        logic [7:0] dio_o;
        logic [7:0] dio_oe;
        logic       dav_o;
        logic       dav_oe;
        logic       nrfd_o;
        logic       nrfd_oe;
        logic       ndac_o;
        logic       ndac_oe;
        logic       eoi_o;
        logic       eoi_oe;
        logic       atn_o;
        logic       atn_oe;
        logic       ifc_o;
        logic       ifc_oe;
        logic       ren_o;
        logic       ren_oe;
    } gph_pin_out_t;

endpackage

// ==== verification/gph_dev.sv ====
// behavioural instrument: address decode, acceptor and source handshakes
module gph_dev (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [4:0]           pa_i,
    input  wire logic [3:0]           dly_i,
    input  wire logic                 srq_req_i,
    input  wire gph_pkg::gph_pin_in_t bus_i,
    input  wire logic [2:0]           mgt_i,
    output gph_pkg::gph_pin_out_t     drv_o,
    output logic                      srq_oe_o,
    output logic                      lad_o,
    output logic                      tad_o,
    output logic                      rem_o,
    output logic                      eoi_o,
    output logic [2:0]                cnt_o,
    output logic [7:0]                buf_o [4]
);
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // decode
    logic [15:0] s1_q, s2_q;
    logic [7:0]  byte_w;
    logic        dav_w, nrfd_w, ndac_w, eoi_w, atn_w, ifc_w, ren_w, acc_w, src_w;
    logic        got_q, dav_q, nrfd_q, ndac_q;
    logic [3:0]  wait_q;
    logic [2:0]  idx_q;
    assign {byte_w, dav_w, nrfd_w, ndac_w, eoi_w} = ~s2_q[15:4];
    assign {atn_w, ifc_w, ren_w} = ~s2_q[2:0];
    assign acc_w = atn_w | lad_o;
    // stops talking after the last stored byte
    assign src_w = tad_o & ~atn_w & (idx_q < cnt_o);
    assign srq_oe_o = srq_req_i;
    always_comb begin
        drv_o = '0;
        drv_o.dio_oe = src_w ? buf_o[idx_q[1:0]] : 8'h00;
        drv_o.eoi_oe = src_w && idx_q == cnt_o - 3'h1;
        drv_o.dav_oe = dav_q;
        drv_o.nrfd_oe = nrfd_q;
        drv_o.ndac_oe = ndac_q;
    end
    // ====================
    // handshake
    always_ff @(posedge core_clk_i) begin
        s1_q <= rst_n_i ? {bus_i, mgt_i} : '1;
        s2_q <= rst_n_i ? s1_q : '1;
        wait_q <= (wait_q != 4'h0) ? wait_q - 4'h1 : 4'h0;
        if (!rst_n_i || ifc_w) begin
            {lad_o, tad_o, rem_o, got_q, dav_q, nrfd_q, ndac_q, idx_q, wait_q, cnt_o, eoi_o} <= '0;
        end else if (src_w) begin
            {nrfd_q, ndac_q, got_q} <= '0;
            if (!dav_q && !nrfd_w && ndac_w && wait_q == 4'h0) dav_q <= 1'b1;
            if (dav_q && !ndac_w) begin
                dav_q <= 1'b0;
                idx_q <= idx_q + 3'h1;
                wait_q <= dly_i;
            end
        end else if (!acc_w) begin
            {nrfd_q, ndac_q, got_q, dav_q} <= '0;
        end else if (dav_w && !got_q) begin
            {got_q, nrfd_q, ndac_q} <= 3'b110;
            if (atn_w) begin
                if (byte_w == 8'h3f) lad_o <= 1'b0;
                if (byte_w == {3'h1, pa_i}) {lad_o, cnt_o} <= 4'h8;
                if (byte_w[7:5] == 3'h2) begin
                    tad_o <= byte_w[4:0] == pa_i;
                    idx_q <= '0;
                end
                // 60h..7fh falls through untouched
            end else begin
                buf_o[cnt_o[1:0]] <= byte_w;
                cnt_o <= cnt_o + 3'h1;
                eoi_o <= eoi_w;
            end
        end else if (!dav_w && got_q) begin
            {got_q, nrfd_q, ndac_q, wait_q} <= {3'b011, dly_i};
        end else if (!got_q) begin
            {nrfd_q, ndac_q} <= {wait_q != 4'h0, 1'b1};
        end
        if (rst_n_i && !ifc_w) rem_o <= ren_w & (rem_o | lad_o | tad_o);
    end
endmodule

// ==== verification/testbench.sv ====
// self-checking bench: bus controller against the instrument model
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // ====================
    // signals
    logic                  core_clk_i = 1'b0;
    logic                  rst_n_i = 1'b0;
    logic                  cmd_valid_i = 1'b0;
    gph_pkg::gph_cmd_t     cmd_i = '0;
    logic                  cmd_ready_o, rsp_valid_o, srq_o, srq_oe, lad, tad, rem, deoi;
    gph_pkg::gph_rsp_t     rsp_o;
    gph_pkg::gph_pin_in_t  pins_i;
    gph_pkg::gph_pin_out_t pins_o, drv;
    logic                  srq_req = 1'b0;
    logic                  dav_p = 1'b0;
    logic [1:0]            rdy_h = 2'b00;
    logic [4:0]            pa = 5'h00;
    logic [3:0]            dly = 4'h0;
    logic [2:0]            mgt, dcnt;
    logic [7:0]            dbuf [4];
    logic [7:0]            msg [4];
    logic [31:0]           seed = 32'hac0e;
    int                    settle = 0;
    int                    failures = 0;
    int                    n_tests = 0;
    // released lines float high
    assign pins_i = ~{pins_o.dio_oe | drv.dio_oe, pins_o.dav_oe | drv.dav_oe, pins_o.nrfd_oe | drv.nrfd_oe,
                      pins_o.ndac_oe | drv.ndac_oe, pins_o.eoi_oe | drv.eoi_oe, srq_oe};
    assign mgt = ~{pins_o.atn_oe, pins_o.ifc_oe, pins_o.ren_oe};
    gph_ctrl #(.TIMEOUT_CYC(200), .IFC_CYC(10)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o),
        .rsp_o(rsp_o), .pins_i(pins_i), .pins_o(pins_o), .srq_o(srq_o));
    // one instrument only
    gph_dev i_dev (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .pa_i(pa), .dly_i(dly), .srq_req_i(srq_req),
        .bus_i(pins_i), .mgt_i(mgt), .drv_o(drv), .srq_oe_o(srq_oe), .lad_o(lad), .tad_o(tad), .rem_o(rem),
        .eoi_o(deoi), .cnt_o(dcnt), .buf_o(dbuf));
    always #2.5 core_clk_i = ~core_clk_i;
    // ====================
    // helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic tick();
        @(posedge core_clk_i);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // request raised for one cycle once ready is seen, then a bounded wait for the answer
    task automatic run(input gph_pkg::gph_op_t op, input logic [7:0] d, input logic e);
        int w;
        w = 0;
        while (cmd_ready_o !== 1'b1 && w < 50) begin
            tick();
            w++;
        end
        `CHK(cmd_ready_o, 1'b1)
        cmd_i = {op, d, e};
        cmd_valid_i = 1'b1;
        tick();
        cmd_valid_i = 1'b0;
        w = 0;
        while (rsp_valid_o !== 1'b1 && w < 1000) begin
            tick();
            w++;
        end
        `CHK(rsp_valid_o, 1'b1)
    endtask
    // ====================
    // wire monitor, sampled at the falling edge where all lines are settled
    always @(negedge core_clk_i) begin
        if (pins_o.dav_oe && !dav_p) begin
            `CHK(rdy_h, 2'b11)
            if (pins_o.atn_oe) `CHK(settle >= gph_pkg::ATN_SETTLE_CYC, 1'b1)
        end
        dav_p = pins_o.dav_oe;
        rdy_h = {rdy_h[0], pins_i.nrfd & ~pins_i.ndac};
        settle = pins_o.atn_oe ? settle + 1 : 0;
    end
    // ====================
    // tests
    initial begin
        int n;
        tick();
        tick();
        rst_n_i = 1'b1;
        tick();
        `CHK({cmd_ready_o, rsp_valid_o, srq_o, pins_o}, {3'b100, 30'h0})
        for (int it = 0; it < 4; it++) begin
            // 31 collides with the unaddress codes, so 0..30 with 0 as corner
            pa = (it == 0) ? 5'h00 : 5'(rnd() % 31);
            dly = 4'(rnd());
            n = it + 1;
            run(gph_pkg::OP_LINE, {6'h0, 1'b1, it[0]}, 1'b0);
            `CHK({lad, tad, rem}, 3'b000)
            run(gph_pkg::OP_CMD, {3'h1, pa}, 1'b0);
            `CHK({lad, rem}, {1'b1, it[0]})
            for (int k = 0; k < n; k++) begin
                msg[k] = 8'(rnd());
                run(gph_pkg::OP_DATA, msg[k], k == n - 1);
            end
            `CHK({dcnt, deoi}, {3'(n), 1'b1})
            for (int k = 0; k < n; k++) `CHK(dbuf[k], msg[k])
            run(gph_pkg::OP_CMD, 8'h3f, 1'b0);
            run(gph_pkg::OP_CMD, {3'h2, pa}, 1'b0);
            `CHK({lad, tad}, 2'b01)
            for (int k = 0; k < n; k++) begin
                run(gph_pkg::OP_RECV, 8'h00, 1'b0);
                `CHK(rsp_o, {msg[k], k == n - 1, 1'b0})
            end
            run(gph_pkg::OP_CMD, 8'h5f, 1'b0);
            run(gph_pkg::OP_DATA, 8'h5a, 1'b0);
            `CHK(rsp_o.err, 1'b1)
            srq_req = 1'b1;
            repeat (4) tick();
            `CHK(srq_o, 1'b1)
            srq_req = 1'b0;
            repeat (4) tick();
            `CHK(srq_o, 1'b0)
            // remote enable alone, without an interface clear pulse
            run(gph_pkg::OP_LINE, 8'h01, 1'b0);
            `CHK({pins_o.ren_oe, pins_o.ifc_oe}, 2'b10)
            $display("pass %0d done", it);
        end
        end_sim();
    end
    // about ten times the expected run length
    initial begin
        #100000;
        failures++;
        end_sim();
    end
endmodule
